// file: inc/dpps_params.svh
`ifndef DPPS_PARAMS_SVH
`define DPPS_PARAMS_SVH
// ********************************************************************
// Register offsets (word addresses on the plain register port)
// ********************************************************************
`define DPPS_A_CTRL 4'h0
`define DPPS_A_STALL 4'h1
`define DPPS_A_OT 4'h2
`define DPPS_A_PUMP 4'h3
`define DPPS_A_DWELL 4'h4
`define DPPS_A_FREQ 4'h5
`define DPPS_A_STAT 4'h6
`define DPPS_A_IRQ 4'h7
`define DPPS_A_MASK 4'h8
// ********************************************************************
// Reset values
// ********************************************************************
`define DPPS_RST_OV_EN 1'h1
`define DPPS_RST_ACC_LVL 8'h96
`define DPPS_RST_CONST_LVL 8'h00
`define DPPS_RST_CONST_DEC 8'h32
`define DPPS_RST_OT_MODE 2'h0
`define DPPS_RST_OT_LVL 8'h00
`define DPPS_RST_OT_TIME 8'h0A
`define DPPS_RST_PUMPS 2'h0
`define DPPS_RST_ROT_MIN 14'h003C
`define DPPS_RST_ILOCK 8'h01
`define DPPS_RST_HI_DWELL 8'h3C
`define DPPS_RST_LO_DWELL 8'h3C
// ********************************************************************
// Timebase: 0.1 s tick at 200 MHz
// ********************************************************************
`define DPPS_CLK_HZ 200000000
`define DPPS_TICK_S_X10 1
`define DPPS_TICK_CYC (`DPPS_CLK_HZ / 10 * `DPPS_TICK_S_X10)
`define DPPS_TICKS_PER_S 8'd10
`define DPPS_TICKS_PER_MIN 10'd600
// Interrupt bit positions
`define DPPS_IRQ_ALARM 0
`define DPPS_IRQ_TRIP 1
`define DPPS_IRQ_ROT 2
`define DPPS_IRQ_STAGE 3
`endif

// file: inc/dpps_pkg.sv
package dpps_pkg;
  // Measured drive inputs
  typedef struct packed {
    logic [7:0] current_pct;
    logic dc_over;
    logic accel;
    logic decel;
    logic at_speed;
    logic running;
    logic [15:0] freq;
  } dpps_meas_t;
  // Ramp requests to the frequency generator
  typedef struct packed {
    logic hold;
    logic lower;
    logic [7:0] lower_rate;
  } dpps_ramp_t;
  typedef enum logic [1:0] {DPPS_P_IDLE, DPPS_P_ON, DPPS_P_GAP} dpps_pump_st_t;
endpackage : dpps_pkg

// file: hdl/dpps_top.sv
`timescale 1ns/1ps
`include "dpps_params.svh"
// Behaviour
// - Over-voltage stall setting 0 disables, 1 enables the function.
// - Decelerating with high DC bus, hold frequency; resume when it falls.
// - Ramp-up current above accel stall level freezes acceleration.
// - Accel stall level zero disables ramp-up stall prevention.
// - Constant speed overcurrent lowers frequency, then returns to set frequency.
// - Constant-speed stall level zero disables that prevention.
// - Frequency lowering rate follows the constant-stall decel time setting.
// - Over-torque modes 0,1 armed after reaching frequency; 1 stops.
// - Over-torque modes 2,3 armed whole run; 3 stops.
// - Over-torque level 0-200%, zero disables detection.
// - Over-torque timing; alarm past half the detect time.
// - Past full detect time, trip: fault and output cut.
// - Auxiliary pump count 0 to 2, each on its own contact.
// - Two pumps, one on duty: rotate duty after rotation time.
// - Interlock delay at changeover, never both contacts on.
// - High-speed dwell reached brings auxiliary pumps in.
// - Low-speed dwell reached stops auxiliary pumps.
module dpps_top #(
  parameter int TICK_CYC = `DPPS_TICK_CYC
) (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire dpps_pkg::dpps_meas_t MEAS,
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output dpps_pkg::dpps_ramp_t RAMP,
  output logic OT_ALARM,
  output logic OT_TRIP,
  output logic [1:0] PUMP_CONTACT,
  output logic IRQ
);
  import dpps_pkg::*;

  // ******************************************************************
  // Settings registers
  // ******************************************************************
  logic ov_stall_enable;
  logic [7:0] accel_stall_level;
  logic [7:0] const_stall_level;
  logic [7:0] const_stall_decel_time;
  logic [1:0] overtorque_mode;
  logic [7:0] overtorque_level;
  logic [7:0] overtorque_time;
  logic [1:0] aux_pump_count;
  logic [13:0] aux_pump_rotation_time;
  logic [7:0] interlock_time;
  logic [7:0] high_speed_dwell_time;
  logic [7:0] low_speed_dwell_time;
  logic [15:0] high_speed_frequency;
  logic [15:0] low_speed_frequency;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic [3:0] irq_event;

  // Software writes; reset loads the default settings
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ov_stall_enable <= `DPPS_RST_OV_EN;
      accel_stall_level <= `DPPS_RST_ACC_LVL;
      const_stall_level <= `DPPS_RST_CONST_LVL;
      const_stall_decel_time <= `DPPS_RST_CONST_DEC;
      overtorque_mode <= `DPPS_RST_OT_MODE;
      overtorque_level <= `DPPS_RST_OT_LVL;
      overtorque_time <= `DPPS_RST_OT_TIME;
      aux_pump_count <= `DPPS_RST_PUMPS;
      aux_pump_rotation_time <= `DPPS_RST_ROT_MIN;
      interlock_time <= `DPPS_RST_ILOCK;
      high_speed_dwell_time <= `DPPS_RST_HI_DWELL;
      low_speed_dwell_time <= `DPPS_RST_LO_DWELL;
      high_speed_frequency <= 16'h0000;
      low_speed_frequency <= 16'h0000;
      irq_mask <= 4'h0;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `DPPS_A_CTRL: begin
          ov_stall_enable <= REG_WDATA[0];
          overtorque_mode <= REG_WDATA[5:4];
          aux_pump_count <= (REG_WDATA[9:8] > 2'h2) ? 2'h2 : REG_WDATA[9:8];
        end
        `DPPS_A_STALL: begin
          accel_stall_level <= clamp200(REG_WDATA[7:0]);
          const_stall_level <= clamp200(REG_WDATA[15:8]);
          const_stall_decel_time <= REG_WDATA[23:16];
        end
        `DPPS_A_OT: begin
          overtorque_level <= clamp200(REG_WDATA[7:0]);
          overtorque_time <= (REG_WDATA[15:8] == 8'h00) ? 8'h01 :
                             (REG_WDATA[15:8] > 8'hC8) ? 8'hC8 : REG_WDATA[15:8];
        end
        `DPPS_A_PUMP: begin
          aux_pump_rotation_time <= (REG_WDATA[13:0] == 14'h0000) ? 14'h0001 :
                                    (REG_WDATA[13:0] > 14'h2328) ? 14'h2328 :
                                    REG_WDATA[13:0];
          interlock_time <= REG_WDATA[23:16];
        end
        `DPPS_A_DWELL: begin
          high_speed_dwell_time <= (REG_WDATA[7:0] == 8'h00) ? 8'h01 : REG_WDATA[7:0];
          low_speed_dwell_time <= (REG_WDATA[15:8] == 8'h00) ? 8'h01 :
                                  (REG_WDATA[15:8] > 8'hFA) ? 8'hFA : REG_WDATA[15:8];
        end
        `DPPS_A_FREQ: begin
          high_speed_frequency <= REG_WDATA[15:0];
          low_speed_frequency <= REG_WDATA[31:16];
        end
        `DPPS_A_MASK: irq_mask <= REG_WDATA[3:0];
        default: ;
      endcase
    end
  end

  // Percent settings top out at 200
  function automatic logic [7:0] clamp200(input logic [7:0] v);
    clamp200 = (v > 8'hC8) ? 8'hC8 : v;
  endfunction : clamp200

  // Dwell reached in whole seconds, shared by both staging timers
  function automatic logic reached_s(input logic [15:0] ticks, input logic [7:0] secs);
    reached_s = ticks >= (16'(secs) * 16'(`DPPS_TICKS_PER_S));
  endfunction : reached_s

  // ******************************************************************
  // 0.1 s timebase
  // ******************************************************************
  logic [31:0] tick_cnt;
  logic tick;
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      tick_cnt <= 32'h0;
    end else if (tick) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end
  assign tick = (tick_cnt == 32'(TICK_CYC - 1));

  // ******************************************************************
  // Stall prevention
  // ******************************************************************
  logic ov_hold, acc_hold, const_low;
  assign ov_hold = ov_stall_enable && MEAS.decel && MEAS.dc_over;
  assign acc_hold = (accel_stall_level != 8'h00) && MEAS.accel &&
                    (MEAS.current_pct > accel_stall_level);
  assign const_low = (const_stall_level != 8'h00) && MEAS.at_speed &&
                     (MEAS.current_pct > const_stall_level);

  // Registered requests; frequency generator returns to set point once lower drops
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      RAMP <= '0;
    end else begin
      RAMP.hold <= ov_hold || acc_hold;
      RAMP.lower <= const_low;
      RAMP.lower_rate <= const_stall_decel_time;
    end
  end

  // ******************************************************************
  // Over-torque detection
  // ******************************************************************
  logic ot_armed, ot_over;
  logic [8:0] ot_ticks;
  assign ot_armed = MEAS.running &&
                    (overtorque_mode[1] || MEAS.at_speed);
  assign ot_over = ot_armed && (overtorque_level != 8'h00) &&
                   (MEAS.current_pct > overtorque_level);

  // Timer counts 0.1 s ticks while over level; trip is sticky until reset
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ot_ticks <= 9'h0;
      OT_ALARM <= 1'b0;
      OT_TRIP <= 1'b0;
    end else if (!ot_over) begin
      ot_ticks <= 9'h0;
      OT_ALARM <= 1'b0;
    end else begin
      if (tick && ot_ticks != 9'h1FF) begin
        ot_ticks <= ot_ticks + 9'h1;
      end
      OT_ALARM <= (10'(ot_ticks) * 10'h2) > 10'(overtorque_time);
      if (ot_ticks > 9'(overtorque_time) && overtorque_mode[0]) begin
        OT_TRIP <= 1'b1;
      end
    end
  end

  // ******************************************************************
  // Auxiliary pump staging and rotation
  // ******************************************************************
  logic [15:0] hi_ticks, lo_ticks;
  logic [9:0] min_ticks;
  logic [13:0] duty_min;
  logic [7:0] gap_ticks;
  logic duty_sel, next_sel, staged;
  dpps_pump_st_t pump_st;
  logic at_hi, at_lo, rotate;
  assign at_hi = MEAS.running && (MEAS.freq >= high_speed_frequency);
  assign at_lo = MEAS.running && (MEAS.freq <= low_speed_frequency);

  // Dwell timers restart whenever the master leaves the band
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || !at_hi || staged) begin
      hi_ticks <= 16'h0;
    end else if (tick && !reached_s(hi_ticks, high_speed_dwell_time)) begin
      hi_ticks <= hi_ticks + 16'h1;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || !at_lo || !staged) begin
      lo_ticks <= 16'h0;
    end else if (tick && !reached_s(lo_ticks, low_speed_dwell_time)) begin
      lo_ticks <= lo_ticks + 16'h1;
    end
  end

  // Staging decision: only the duty pump runs, with one pump or two
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || aux_pump_count == 2'h0 || OT_TRIP) begin
      staged <= 1'b0;
    end else if (!staged && at_hi && reached_s(hi_ticks, high_speed_dwell_time)) begin
      staged <= 1'b1;
    end else if (staged && at_lo && reached_s(lo_ticks, low_speed_dwell_time)) begin
      staged <= 1'b0;
    end
  end

  assign rotate = (pump_st == DPPS_P_ON) && (aux_pump_count == 2'h2) &&
                  (duty_min >= aux_pump_rotation_time);

  // Duty runtime in minutes
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || pump_st != DPPS_P_ON) begin
      min_ticks <= 10'h0;
      duty_min <= 14'h0;
    end else if (tick) begin
      if (min_ticks == `DPPS_TICKS_PER_MIN - 10'h1) begin
        min_ticks <= 10'h0;
        duty_min <= duty_min + 14'h1;
      end else begin
        min_ticks <= min_ticks + 10'h1;
      end
    end
  end

  // Duty pump state; gap keeps both contacts open during the handover
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      pump_st <= DPPS_P_IDLE;
      duty_sel <= 1'b0;
      next_sel <= 1'b0;
      gap_ticks <= 8'h0;
    end else begin
      case (pump_st)
        DPPS_P_IDLE: begin
          if (staged) pump_st <= DPPS_P_ON;
        end
        DPPS_P_ON: begin
          if (!staged) begin
            pump_st <= DPPS_P_IDLE;
          end else if (rotate) begin
            next_sel <= ~duty_sel;
            gap_ticks <= 8'h0;
            pump_st <= DPPS_P_GAP;
          end
        end
        DPPS_P_GAP: begin
          if (!staged) begin
            pump_st <= DPPS_P_IDLE;
          end else if (gap_ticks >= interlock_time) begin
            duty_sel <= next_sel;
            pump_st <= DPPS_P_ON;
          end else if (tick) begin
            gap_ticks <= gap_ticks + 8'h1;
          end
        end
        default: pump_st <= DPPS_P_IDLE;
      endcase
    end
  end

  // Contacts: one per pump, never both during a changeover
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || pump_st != DPPS_P_ON || aux_pump_count == 2'h0) begin
      PUMP_CONTACT <= 2'b00;
    end else if (aux_pump_count == 2'h1) begin
      PUMP_CONTACT <= 2'b01;
    end else begin
      PUMP_CONTACT <= duty_sel ? 2'b10 : 2'b01;
    end
  end

  // ******************************************************************
  // Interrupts and read port
  // ******************************************************************
  logic alarm_q, trip_q;
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      alarm_q <= 1'b0;
      trip_q <= 1'b0;
    end else begin
      alarm_q <= OT_ALARM;
      trip_q <= OT_TRIP;
    end
  end
  assign irq_event = {(pump_st == DPPS_P_IDLE) && staged, rotate,
                      OT_TRIP && !trip_q, OT_ALARM && !alarm_q};

  // Set beats write-one-to-clear in the same cycle
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      irq_stat <= 4'h0;
    end else begin
      irq_stat <= (irq_stat & ~((REG_WR && REG_ADDR == `DPPS_A_IRQ) ? REG_WDATA[3:0] : 4'h0))
                  | irq_event;
    end
  end
  assign IRQ = |(irq_stat & irq_mask);

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || !REG_RD) begin
      REG_RDATA <= 32'h0;
    end else begin
      case (REG_ADDR)
        `DPPS_A_CTRL: REG_RDATA <= {22'h0, aux_pump_count, 2'h0, overtorque_mode,
                                    3'h0, ov_stall_enable};
        `DPPS_A_STALL: REG_RDATA <= {8'h0, const_stall_decel_time, const_stall_level,
                                     accel_stall_level};
        `DPPS_A_OT: REG_RDATA <= {16'h0, overtorque_time, overtorque_level};
        `DPPS_A_PUMP: REG_RDATA <= {8'h0, interlock_time, 2'h0, aux_pump_rotation_time};
        `DPPS_A_DWELL: REG_RDATA <= {16'h0, low_speed_dwell_time, high_speed_dwell_time};
        `DPPS_A_FREQ: REG_RDATA <= {low_speed_frequency, high_speed_frequency};
        `DPPS_A_STAT: REG_RDATA <= {18'h0, duty_min[5:0], PUMP_CONTACT, staged,
                                    RAMP.lower, RAMP.hold, OT_TRIP, OT_ALARM, duty_sel};
        `DPPS_A_IRQ: REG_RDATA <= {28'h0, irq_stat};
        `DPPS_A_MASK: REG_RDATA <= {28'h0, irq_mask};
        default: REG_RDATA <= 32'h0;
      endcase
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  property p_ov_hold;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (ov_stall_enable && MEAS.decel && MEAS.dc_over) |=> RAMP.hold;
  endproperty
  a_ov_hold: assert property (p_ov_hold) else $error("ov stall hold missing");

  property p_ov_off;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (!ov_stall_enable && !acc_hold) |=> !RAMP.hold;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("hold while disabled");

  property p_acc_zero;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (accel_stall_level == 8'h00 && !ov_hold) |=> !RAMP.hold;
  endproperty
  a_acc_zero: assert property (p_acc_zero) else $error("accel stall not off");

  property p_const;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    RAMP.lower |-> $past(const_stall_level) != 8'h00 && $past(MEAS.at_speed);
  endproperty
  a_const: assert property (p_const) else $error("lower without cause");

  property p_ot_clear;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    !ot_over |=> ot_ticks == 9'h0 && !OT_ALARM;
  endproperty
  a_ot_clear: assert property (p_ot_clear) else $error("ot timer not cleared");

  property p_ot_zero;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    overtorque_level == 8'h00 |=> !OT_ALARM;
  endproperty
  a_ot_zero: assert property (p_ot_zero) else $error("alarm while disabled");

  property p_trip_stops;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    $rose(OT_TRIP) |-> $past(overtorque_mode[0]) && $past(ot_ticks) > 9'($past(overtorque_time));
  endproperty
  a_trip_stops: assert property (p_trip_stops) else $error("bad trip");

  sequence s_leave_on;
    pump_st == DPPS_P_ON ##1 pump_st == DPPS_P_GAP;
  endsequence
  property p_gap;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    s_leave_on |=> PUMP_CONTACT == 2'b00;
  endproperty
  a_gap: assert property (p_gap) else $error("contacts closed in gap");

  property p_never_both;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    PUMP_CONTACT != 2'b11;
  endproperty
  a_never_both: assert property (p_never_both) else $error("both pumps on");

  property p_stage_in;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    $rose(staged) |-> $past(reached_s(hi_ticks, high_speed_dwell_time));
  endproperty
  a_stage_in: assert property (p_stage_in) else $error("early staging");
endmodule : dpps_top

// file: dv/dpps_plant.sv
`timescale 1ns/1ps
// ********************************************************************
// Power stage and motor stand-in
// ********************************************************************
module dpps_plant (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] load_pct,
  input wire logic [2:0] phase,
  input wire logic bus_high,
  input wire logic [15:0] freq_cmd,
  input wire dpps_pkg::dpps_ramp_t ramp,
  input wire logic trip,
  output dpps_pkg::dpps_meas_t meas
);
  import dpps_pkg::*;

  // Trip cuts the output, so current and motion go away with it
  always_ff @(posedge clk) begin
    if (rst) begin
      meas <= '0;
    end else begin
      meas.current_pct <= trip ? 8'h00 : load_pct;
      meas.dc_over <= bus_high;
      meas.decel <= phase[2] & ~trip;
      meas.accel <= phase[1] & ~trip;
      meas.at_speed <= phase[0] & ~trip;
      meas.running <= ~trip;
      // A held ramp freezes the frequency, as the real stage would
      if (!ramp.hold) begin
        meas.freq <= freq_cmd;
      end
    end
  end
endmodule : dpps_plant

// file: dv/testbench.sv
`timescale 1ns/1ps
`include "dpps_params.svh"
// ********************************************************************
// Top-level bench
// ********************************************************************
module testbench;
  import dpps_pkg::*;
  logic clk_sys;
  logic sys_rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] load = 8'h00;
  logic [2:0] phase = 3'h0;
  logic bus_high = 1'b0;
  logic [15:0] freq = 16'h0000;
  logic [31:0] rdata;
  dpps_meas_t meas;
  dpps_ramp_t ramp;
  logic ot_alarm;
  logic ot_trip;
  logic [1:0] pump;
  logic irq;
  logic [6:0] obs;
  logic [31:0] d;
  int n_fail = 0;
  int cmp_count = 0;
  // Index 0 hold, 1 lower, 2 alarm, 3 trip, 4 pump1, 5 pump2, 6 irq
  assign obs = {irq, pump, ot_trip, ot_alarm, ramp.lower, ramp.hold};

  dpps_top #(.TICK_CYC(10)) dpps_top_i (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .MEAS(meas), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr_stb), .REG_RD(rd_stb), .REG_RDATA(rdata),
    .RAMP(ramp), .OT_ALARM(ot_alarm), .OT_TRIP(ot_trip), .PUMP_CONTACT(pump), .IRQ(irq)
  );
  dpps_plant dpps_plant_i (
    .clk(clk_sys), .rst(sys_rst), .load_pct(load), .phase(phase), .bus_high(bus_high),
    .freq_cmd(freq), .ramp(ramp), .trip(ot_trip), .meas(meas)
  );

  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ******************************************************************
  // Tasks
  // ******************************************************************
  task automatic report_and_stop();
    $display("fails %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Bounded wait for an output to reach a level
  task automatic wait_for(input int idx, input logic val, input int lim, input string what);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (obs[idx] !== val && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    chk({31'h0, obs[idx]}, {31'h0, val}, what);
  endtask : wait_for

  // An output must not show the level for the whole span
  task automatic never(input int idx, input logic val, input int lim, input string what);
    logic seen;
    seen = 1'b0;
    repeat (lim) begin
      @(negedge clk_sys);
      if (obs[idx] === val) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h0, what);
  endtask : never

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    @(negedge clk_sys);
    v = rdata;
  endtask : reg_rd

  task automatic drive(input logic [7:0] ld, input logic [2:0] ph, input logic hb,
                       input logic [15:0] f);
    @(posedge clk_sys);
    load <= ld;
    phase <= ph;
    bus_high <= hb;
    freq <= f;
  endtask : drive

  task automatic do_reset();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask : do_reset

  // Both contacts together is never allowed, changeover included
  always @(negedge clk_sys) begin
    if (!sys_rst && pump === 2'b11) chk({30'h0, pump}, 32'h1, "both pumps on");
  end

  // Hang guard, well beyond the longest sequence
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_fail++;
    report_and_stop();
  end

  // ******************************************************************
  // Tests
  // ******************************************************************
  initial begin
    logic [3:0] ra[6];
    logic [31:0] rx[6];
    ra = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h9};
    rx = '{32'h1, 32'h00320096, 32'h00000A00, 32'h0001003C, 32'h00003C3C, 32'h0};
    do_reset();
    foreach (ra[i]) begin
      reg_rd(ra[i], d);
      chk(d, rx[i], "reset value");
    end
    // Over-voltage stall while decelerating
    drive(8'h00, 3'b100, 1'b1, 16'h0000);
    wait_for(0, 1'b1, 5, "ov hold on");
    drive(8'h00, 3'b100, 1'b0, 16'h0000);
    wait_for(0, 1'b0, 5, "ov hold off");
    reg_wr(`DPPS_A_CTRL, 32'h0);
    drive(8'h00, 3'b100, 1'b1, 16'h0000);
    never(0, 1'b1, 10, "ov disabled");
    // Ramp-up stall at the 150 boundary
    drive(8'd151, 3'b010, 1'b0, 16'h0000);
    wait_for(0, 1'b1, 5, "accel hold");
    drive(8'd150, 3'b010, 1'b0, 16'h0000);
    wait_for(0, 1'b0, 5, "accel resume");
    reg_wr(`DPPS_A_STALL, 32'h00320000);
    drive(8'd200, 3'b010, 1'b0, 16'h0000);
    never(0, 1'b1, 10, "accel disabled");
    // Constant-speed stall
    reg_wr(`DPPS_A_STALL, 32'h00217896);
    drive(8'd121, 3'b001, 1'b0, 16'h0000);
    wait_for(1, 1'b1, 5, "lower on");
    chk({24'h0, ramp.lower_rate}, 32'h21, "lower rate");
    drive(8'd120, 3'b001, 1'b0, 16'h0000);
    wait_for(1, 1'b0, 5, "lower off");
    reg_wr(`DPPS_A_STALL, 32'h00210096);
    drive(8'd200, 3'b001, 1'b0, 16'h0000);
    never(1, 1'b1, 10, "const disabled");
    // Over-torque, level 100, time 0.4 s
    reg_wr(`DPPS_A_MASK, 32'h3);
    reg_wr(`DPPS_A_OT, 32'h00000464);
    reg_wr(`DPPS_A_CTRL, 32'h10);
    drive(8'd101, 3'b010, 1'b0, 16'h0000);
    never(2, 1'b1, 100, "mode 1 not armed");
    drive(8'd101, 3'b001, 1'b0, 16'h0000);
    wait_for(2, 1'b1, 60, "alarm");
    // Status bit lands one clock after the alarm edge
    @(negedge clk_sys);
    chk({30'h0, ot_trip, irq}, 32'h1, "no trip yet, irq");
    drive(8'd100, 3'b001, 1'b0, 16'h0000);
    wait_for(2, 1'b0, 5, "alarm clears");
    reg_rd(`DPPS_A_IRQ, d);
    chk(d & 32'h1, 32'h1, "alarm status");
    reg_wr(`DPPS_A_IRQ, 32'hF);
    reg_rd(`DPPS_A_IRQ, d);
    chk({d[30:0], irq}, 32'h0, "status cleared");
    // Modes 0 and 2: armed at speed or whole run, alarm only, never a trip
    reg_wr(`DPPS_A_CTRL, 32'h0);
    drive(8'd101, 3'b001, 1'b0, 16'h0000);
    wait_for(2, 1'b1, 60, "mode 0 alarm");
    never(3, 1'b1, 100, "mode 0 no trip");
    drive(8'd0, 3'b010, 1'b0, 16'h0000);
    wait_for(2, 1'b0, 5, "mode 0 alarm drop");
    reg_wr(`DPPS_A_CTRL, 32'h20);
    drive(8'd101, 3'b010, 1'b0, 16'h0000);
    wait_for(2, 1'b1, 60, "mode 2 alarm");
    never(3, 1'b1, 100, "mode 2 no trip");
    drive(8'd0, 3'b010, 1'b0, 16'h0000);
    wait_for(2, 1'b0, 5, "alarm drop");
    reg_wr(`DPPS_A_OT, 32'h00000400);
    drive(8'd200, 3'b010, 1'b0, 16'h0000);
    never(2, 1'b1, 100, "ot disabled");
    // Mode 3 trip with the alarm masked
    drive(8'd0, 3'b010, 1'b0, 16'h0000);
    reg_wr(`DPPS_A_IRQ, 32'hF);
    reg_wr(`DPPS_A_MASK, 32'h2);
    reg_wr(`DPPS_A_OT, 32'h00000464);
    reg_wr(`DPPS_A_CTRL, 32'h30);
    drive(8'd101, 3'b010, 1'b0, 16'h0000);
    wait_for(2, 1'b1, 60, "mode 3 alarm");
    chk({31'h0, irq}, 32'h0, "alarm masked");
    wait_for(3, 1'b1, 60, "trip");
    wait_for(6, 1'b1, 3, "trip irq");
    drive(8'd0, 3'b010, 1'b0, 16'h0000);
    never(3, 1'b0, 20, "trip sticky");
    do_reset();
    wait_for(3, 1'b0, 1, "trip reset");
    // Pump staging and rotation: dwell 1 s, rotation 1 min
    reg_wr(`DPPS_A_CTRL, 32'h200);
    reg_wr(`DPPS_A_DWELL, 32'h00000101);
    reg_wr(`DPPS_A_FREQ, {16'd1000, 16'd4000});
    reg_wr(`DPPS_A_PUMP, 32'h00020001);
    drive(8'd50, 3'b001, 1'b0, 16'd4000);
    repeat (60) @(negedge clk_sys);
    drive(8'd50, 3'b001, 1'b0, 16'd3000);
    repeat (5) @(negedge clk_sys);
    drive(8'd50, 3'b001, 1'b0, 16'd4000);
    never(4, 1'b1, 80, "dwell restart");
    wait_for(4, 1'b1, 60, "staged");
    reg_rd(`DPPS_A_STAT, d);
    chk(d, 32'h60, "status staged");
    reg_rd(`DPPS_A_IRQ, d);
    chk(d, 32'h8, "staging event");
    wait_for(4, 1'b0, 6100, "duty handover");
    chk({30'h0, pump}, 32'h0, "interlock gap");
    wait_for(5, 1'b1, 40, "second pump");
    reg_rd(`DPPS_A_IRQ, d);
    chk(d, 32'hC, "rotation event");
    drive(8'd50, 3'b001, 1'b0, 16'd1000);
    wait_for(5, 1'b0, 130, "unstaged");
    reg_wr(`DPPS_A_CTRL, 32'h0);
    drive(8'd50, 3'b001, 1'b0, 16'd4000);
    never(4, 1'b1, 150, "no pumps one");
    never(5, 1'b1, 50, "no pumps two");
    report_and_stop();
  end
endmodule : testbench
